// ===== hw/power_fail_state_control.sv
// Power-fail state controller with eight configurable digital terminals
//
// How it works
// - React only to dropouts longer than 5 ms
// - Executing goes persisting on qualified undervoltage
// - State is always one of four values
// - Executing lets program run undisturbed
// - Persisting halts program at once
// - Persisting disables outputs, permit and indicator
// - Persisting commands non-volatile save
// - Save done, no recovery: go waiting
// - Waiting holds program while reserve lasts
// - Reserve exhausted: enter dead state
// - Waiting keeps outputs off below 18 V
// - Recovery from waiting reruns start sequence
// - Stay persisting until save completes
// - Recovered during save: restart directly
// - Classify event long or short duration
// - Eight terminals, each input or output
// - Outputs looped back for readback
// - Start: load project, restore, maybe start
// - Permit low blocks every terminal output
`timescale 1ns/1ps

module power_fail_state_control #(
  parameter int unsigned DROPOUT_CYCLES = power_fail_pkg::DROPOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Supply comparator (asynchronous pins)
  input  wire logic        i_supply_low,
  input  wire logic        i_supply_above_18v,
  // Save engine and reserve monitor (same clock)
  input  wire logic        i_save_done,
  input  wire logic        i_reserve_exhausted,
  output logic             o_save_req,
  // Start sequence helpers
  output logic             o_load_project,
  output logic             o_restore_vars,
  input  wire logic        i_step_done,
  // Program control
  output logic             o_program_run,
  output logic             o_module_active,
  // Permit signal and its indicator
  output logic             o_output_permit,
  output logic             o_output_permit_indicator,
  // Digital terminals
  input  wire logic [7:0]  i_digital_terminals,
  output logic      [7:0]  o_digital_terminals,
  output logic      [7:0]  o_digital_terminals_oe_n
);

  // Reset synchroniser
  logic rst_meta_n;
  logic rst_n;

  // Release of reset through two flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Pin synchronisers: three stages, change accepted when stages two and three agree
  logic [2:0] low_sync;
  logic [2:0] high_sync;
  logic [7:0] term_s1;
  logic [7:0] term_s2;
  logic [7:0] term_s3;
  logic       low_q;            // Filtered low indication
  logic       high_q;           // Filtered recovery indication
  logic [7:0] term_q;           // Filtered terminal levels
  logic       next_low_q;
  logic       next_high_q;
  logic [7:0] next_term_q;

  // Accept a level only when both later stages agree
  always_comb begin
    next_low_q  = (low_sync[1] == low_sync[2]) ? low_sync[2] : low_q;
    next_high_q = (high_sync[1] == high_sync[2]) ? high_sync[2] : high_q;
    for (int i = 0; i < 8; i++) begin
      next_term_q[i] = (term_s2[i] == term_s3[i]) ? term_s3[i] : term_q[i];
    end
  end

  // Synchroniser stages
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_sync  <= 3'h0;
      high_sync <= 3'h7;
      term_s1   <= 8'h00;
      term_s2   <= 8'h00;
      term_s3   <= 8'h00;
      low_q     <= 1'b0;
      high_q    <= 1'b1;
      term_q    <= 8'h00;
    end else begin
      low_sync  <= {low_sync[1:0], i_supply_low};
      high_sync <= {high_sync[1:0], i_supply_above_18v};
      term_s1   <= i_digital_terminals;
      term_s2   <= term_s1;
      term_s3   <= term_s2;
      low_q     <= next_low_q;
      high_q    <= next_high_q;
      term_q    <= next_term_q;
    end
  end

  // Dropout qualification: counter restarts on every return of the supply
  logic [power_fail_pkg::DROPOUT_W-1:0] drop_cnt;
  logic [power_fail_pkg::DROPOUT_W-1:0] next_drop_cnt;
  logic                                 undervolt;      // Qualified undervoltage
  logic                                 next_undervolt;

  // Count dropout time, saturate at the limit
  always_comb begin
    next_drop_cnt  = drop_cnt;
    next_undervolt = 1'b0;
    if (!low_q) begin
      next_drop_cnt = '0;
    end else if (drop_cnt < DROPOUT_CYCLES[power_fail_pkg::DROPOUT_W-1:0]) begin
      next_drop_cnt = drop_cnt + 1'b1;
    end else begin
      next_undervolt = 1'b1;
    end
  end

  // Dropout registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt  <= '0;
      undervolt <= 1'b0;
    end else begin
      drop_cnt  <= next_drop_cnt;
      undervolt <= next_undervolt;
    end
  end

  // Registers seen by software
  logic [2:0] ctrl;             // Permit request, last start command, project present
  logic [7:0] direction;        // One per terminal: 1 = output
  logic [7:0] out_cmd;          // Commanded output levels
  logic [2:0] next_ctrl;
  logic [7:0] next_direction;
  logic [7:0] next_out_cmd;
  logic       apb_wr;
  logic       apb_rd;
  logic [31:0] rdata_mux;

  // Control and start sequence state
  power_fail_pkg::ctrl_state_type state;
  power_fail_pkg::ctrl_state_type next_state;
  power_fail_pkg::boot_step_type  boot;
  power_fail_pkg::boot_step_type  next_boot;
  logic run;
  logic next_run;
  logic recovered;              // Supply came back during the save
  logic next_recovered;
  logic long_evt;
  logic short_evt;
  logic next_long_evt;
  logic next_short_evt;

  assign apb_wr = i_psel && i_penable && i_pwrite;
  // Read captured in the setup cycle so the data stands through the access cycle
  assign apb_rd = i_psel && !i_penable && !i_pwrite;

  // Register writes, honouring the low byte strobe
  always_comb begin
    next_ctrl      = ctrl;
    next_direction = direction;
    next_out_cmd   = out_cmd;
    if (apb_wr && i_pstrb[0]) begin
      case (i_paddr)
        power_fail_pkg::ADDR_CONTROL:   next_ctrl      = i_pwdata[2:0];
        power_fail_pkg::ADDR_DIRECTION: next_direction = i_pwdata[7:0];
        power_fail_pkg::ADDR_OUT_CMD:   next_out_cmd   = i_pwdata[7:0];
        default:                        next_ctrl      = ctrl;
      endcase
    end
  end

  // Read mux; status shows the block's own state
  always_comb begin
    rdata_mux = 32'h0000_0000;
    case (i_paddr)
      power_fail_pkg::ADDR_CONTROL:   rdata_mux[2:0] = ctrl;
      power_fail_pkg::ADDR_DIRECTION: rdata_mux[7:0] = direction;
      power_fail_pkg::ADDR_OUT_CMD:   rdata_mux[7:0] = out_cmd;
      power_fail_pkg::ADDR_STATUS: begin
        rdata_mux[power_fail_pkg::STAT_STATE_LSB +: 2] = state;
        rdata_mux[power_fail_pkg::STAT_BOOT_LSB +: 3]  = boot;
        rdata_mux[power_fail_pkg::STAT_RUN_BIT]        = run;
        rdata_mux[power_fail_pkg::STAT_LONG_BIT]       = long_evt;
        rdata_mux[power_fail_pkg::STAT_SHORT_BIT]      = short_evt;
        rdata_mux[power_fail_pkg::STAT_PERMIT_BIT]     = o_output_permit;
      end
      power_fail_pkg::ADDR_TERM_READ: rdata_mux[7:0] = term_q;
      default:                        rdata_mux = 32'h0000_0000;
    endcase
  end

  // Main state machine; exactly four states, encoded in two bits
  always_comb begin
    next_state     = state;
    next_boot      = boot;
    next_run       = run;
    next_recovered = recovered;
    next_long_evt  = long_evt;
    next_short_evt = short_evt;
    case (state)
      power_fail_pkg::ST_EXECUTING: begin
        // Start sequence in steps, then the program runs untouched if project present and start commanded
        case (boot)
          power_fail_pkg::BOOT_IDLE: next_boot = power_fail_pkg::BOOT_LOAD;
          power_fail_pkg::BOOT_LOAD: begin
            if (!ctrl[power_fail_pkg::CTRL_PROJECT_BIT]) begin
              next_boot = power_fail_pkg::BOOT_RESTORE;
            end else if (i_step_done) begin
              next_boot = power_fail_pkg::BOOT_RESTORE;
            end
          end
          power_fail_pkg::BOOT_RESTORE: begin
            if (i_step_done) begin
              next_boot = power_fail_pkg::BOOT_DECIDE;
            end
          end
          power_fail_pkg::BOOT_DECIDE: begin
            next_run  = ctrl[power_fail_pkg::CTRL_PROJECT_BIT]
                        && ctrl[power_fail_pkg::CTRL_START_CMD_BIT];
            next_boot = power_fail_pkg::BOOT_DONE;
          end
          power_fail_pkg::BOOT_DONE: next_boot = boot;
          default:                   next_boot = power_fail_pkg::BOOT_IDLE;
        endcase
        if (undervolt) begin
          next_state     = power_fail_pkg::ST_PERSISTING;
          next_run       = 1'b0;
          next_recovered = 1'b0;
          next_boot      = power_fail_pkg::BOOT_IDLE;
        end
      end
      power_fail_pkg::ST_PERSISTING: begin
        // Remember a recovery seen while the save still runs
        if (high_q) begin
          next_recovered = 1'b1;
        end
        if (i_save_done) begin
          if (recovered || high_q) begin
            next_state     = power_fail_pkg::ST_EXECUTING;
            next_short_evt = 1'b1;
          end else begin
            next_state    = power_fail_pkg::ST_WAITING;
            next_long_evt = 1'b1;
          end
        end
      end
      power_fail_pkg::ST_WAITING: begin
        if (i_reserve_exhausted) begin
          next_state = power_fail_pkg::ST_DEAD;
        end else if (high_q) begin
          next_state = power_fail_pkg::ST_EXECUTING;
        end else begin
          next_state = power_fail_pkg::ST_WAITING;
        end
      end
      power_fail_pkg::ST_DEAD:  next_state = power_fail_pkg::ST_DEAD;
      default:                  next_state = power_fail_pkg::ST_DEAD;
    endcase
  end

  // Registered outputs follow the next state
  logic       next_save_req;
  logic       next_permit;
  logic [7:0] next_term_out;
  logic [7:0] next_term_oe_n;

  // Output decode from next values so outputs are flops
  always_comb begin
    next_save_req  = (next_state == power_fail_pkg::ST_PERSISTING);
    next_permit    = (next_state == power_fail_pkg::ST_EXECUTING)
                     && (next_boot == power_fail_pkg::BOOT_DONE)
                     && next_ctrl[power_fail_pkg::CTRL_PERMIT_BIT];
    for (int i = 0; i < 8; i++) begin
      // Input terminals never drive; outputs only with permit high
      next_term_oe_n[i] = !(next_direction[i] && next_permit);
      next_term_out[i]  = next_out_cmd[i] && next_direction[i] && next_permit;
    end
  end

  // State and output registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= power_fail_pkg::ST_EXECUTING;
      boot      <= power_fail_pkg::BOOT_IDLE;
      run       <= 1'b0;
      recovered <= 1'b0;
      long_evt  <= 1'b0;
      short_evt <= 1'b0;
      ctrl      <= power_fail_pkg::RST_CONTROL;
      direction <= power_fail_pkg::RST_DIRECTION;
      out_cmd   <= power_fail_pkg::RST_OUT_CMD;
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_save_req                <= 1'b0;
      o_load_project            <= 1'b0;
      o_restore_vars            <= 1'b0;
      o_program_run             <= 1'b0;
      o_module_active           <= 1'b1;
      o_output_permit           <= 1'b0;
      o_output_permit_indicator <= 1'b0;
      o_digital_terminals       <= 8'h00;
      o_digital_terminals_oe_n  <= 8'hFF;
    end else begin
      state     <= next_state;
      boot      <= next_boot;
      run       <= next_run;
      recovered <= next_recovered;
      long_evt  <= next_long_evt;
      short_evt <= next_short_evt;
      ctrl      <= next_ctrl;
      direction <= next_direction;
      out_cmd   <= next_out_cmd;
      // Zero-wait slave: pready in the access cycle, stored read data
      o_prdata  <= apb_rd ? rdata_mux : 32'h0000_0000;
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_save_req                <= next_save_req;
      o_load_project            <= (next_boot == power_fail_pkg::BOOT_LOAD)
                                   && next_ctrl[power_fail_pkg::CTRL_PROJECT_BIT];
      o_restore_vars            <= (next_boot == power_fail_pkg::BOOT_RESTORE);
      o_program_run             <= next_run;
      o_module_active           <= (next_state != power_fail_pkg::ST_DEAD);
      o_output_permit           <= next_permit;
      o_output_permit_indicator <= next_permit;
      o_digital_terminals       <= next_term_out;
      o_digital_terminals_oe_n  <= next_term_oe_n;
    end
  end

endmodule

// ===== include/power_fail_pkg.sv
// Package with constants and types for the power-fail state controller
package power_fail_pkg;

  // Clock rate and derived periods
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned DROPOUT_MS      = 5;
  // More than 5 ms of dropout is needed, so one cycle beyond the truncated 5 ms count
  localparam int unsigned DROPOUT_CYCLES  = (DROPOUT_MS * (CLK_HZ / 1000)) + 1;
  localparam int unsigned DROPOUT_W       = 20;

  // Terminal count and APB register map
  localparam int unsigned NUM_TERMINALS   = 8;
  localparam logic [11:0] ADDR_CONTROL    = 12'h000;
  localparam logic [11:0] ADDR_DIRECTION  = 12'h004;
  localparam logic [11:0] ADDR_OUT_CMD    = 12'h008;
  localparam logic [11:0] ADDR_STATUS     = 12'h00C;
  localparam logic [11:0] ADDR_TERM_READ  = 12'h010;

  // Field positions
  localparam int unsigned CTRL_PERMIT_BIT     = 0;
  localparam int unsigned CTRL_START_CMD_BIT  = 1;
  localparam int unsigned CTRL_PROJECT_BIT    = 2;
  localparam int unsigned STAT_STATE_LSB      = 0;
  localparam int unsigned STAT_BOOT_LSB       = 4;
  localparam int unsigned STAT_RUN_BIT        = 8;
  localparam int unsigned STAT_LONG_BIT       = 9;
  localparam int unsigned STAT_SHORT_BIT      = 10;
  localparam int unsigned STAT_PERMIT_BIT     = 11;

  // Reset values
  localparam logic [7:0]  RST_DIRECTION   = 8'h00;
  localparam logic [7:0]  RST_OUT_CMD     = 8'h00;
  localparam logic [2:0]  RST_CONTROL     = 3'h0;

  // Control states
  typedef enum logic [1:0] {
    ST_EXECUTING,
    ST_PERSISTING,
    ST_WAITING,
    ST_DEAD
  } ctrl_state_type;

  // Start sequence steps
  typedef enum logic [2:0] {
    BOOT_IDLE,
    BOOT_LOAD,
    BOOT_RESTORE,
    BOOT_DECIDE,
    BOOT_DONE
  } boot_step_type;

endpackage

// ===== tb/power_fail_state_control_asserts.sv
// Port-level checker for the power-fail controller
`timescale 1ns/1ps
module power_fail_state_control_asserts #(
  parameter int unsigned DROPOUT_CYCLES = 20
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  // Causes
  input wire logic       i_supply_low,
  input wire logic       i_save_done,
  input wire logic       i_reserve_exhausted,
  // Effects
  input wire logic       o_save_req,
  input wire logic       o_program_run,
  input wire logic       o_module_active,
  input wire logic       o_output_permit,
  input wire logic       o_output_permit_indicator,
  input wire logic [7:0] o_digital_terminals_oe_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  int low_run;      // Consecutive cycles with the supply pin low
  int next_low_run; // Next count
  always_comb begin
    next_low_run = i_supply_low ? low_run + 1 : 0;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_run <= 0;
    end else begin
      low_run <= next_low_run;
    end
  end
  // Save phase steps and two cycles of permit low
  sequence save_open_s;
    o_save_req && !i_save_done;
  endsequence
  sequence save_ends_s;
    o_save_req ##1 !o_save_req;
  endsequence
  sequence permit_off_s;
    !o_output_permit ##1 !o_output_permit;
  endsequence
  dropout_len_a: assert property ($rose(o_save_req) |-> low_run > DROPOUT_CYCLES)
    else $error("save started after a short dropout");
  save_quiet_a: assert property (o_save_req |-> !o_program_run && !o_output_permit)
    else $error("program or permit active while saving");
  permit_led_a: assert property (o_output_permit == o_output_permit_indicator)
    else $error("permit indicator differs from permit");
  term_block_a: assert property (permit_off_s |-> o_digital_terminals_oe_n == 8'hFF)
    else $error("terminal driven while permit low");
  save_hold_a: assert property (save_open_s |=> o_save_req)
    else $error("left save before completion");
  save_exit_a: assert property (o_save_req && i_save_done |=> !o_save_req)
    else $error("save done not acted on");
  restart_quiet_a: assert property (save_ends_s |-> !o_program_run)
    else $error("program running straight after save");
  dead_stay_a: assert property (!o_module_active |=> !o_module_active)
    else $error("dead state left without reset");
  dead_cause_a: assert property ($fell(o_module_active) |-> $past(i_reserve_exhausted))
    else $error("dead without reserve exhausted");
endmodule
bind power_fail_state_control power_fail_state_control_asserts #(
  .DROPOUT_CYCLES(DROPOUT_CYCLES)
) power_fail_state_control_asserts_inst (
  .i_clk, .i_arst_n, .i_supply_low, .i_save_done, .i_reserve_exhausted,
  .o_save_req, .o_program_run, .o_module_active, .o_output_permit,
  .o_output_permit_indicator, .o_digital_terminals_oe_n
);

// ===== tb/power_fail_state_control_tb.sv
// Self-checking bench for the power-fail controller
`timescale 1ns/1ps
module power_fail_state_control_tb;
  localparam int unsigned DROP = 20; // Shortened dropout count
  // Bench-driven inputs
  logic        clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        sup_low = 1'h0, sup_ok = 1'h1, exhaust = 1'h0, slow = 1'h0;
  logic [7:0]  ext = 8'h00;
  // Design outputs and partner wires
  logic [31:0] prdata, r;
  logic        pready, save_done, save_req, load, restore, step_done, run, active, permit;
  logic [7:0]  term_in, term_out, oe_n, dir, cmd;
  // Bookkeeping
  int          bad_count = 0, samples_checked = 0, cycles = 0, seed = 32'h44c7;
  logic        saw_load = 1'h0; // Project load step seen
  power_fail_state_control #(.DROPOUT_CYCLES(DROP)) power_fail_state_control_inst (
    .i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(), .i_supply_low(sup_low),
    .i_supply_above_18v(sup_ok), .i_save_done(save_done), .i_reserve_exhausted(exhaust),
    .o_save_req(save_req), .o_load_project(load), .o_restore_vars(restore),
    .i_step_done(step_done), .o_program_run(run), .o_module_active(active),
    .o_output_permit(permit), .o_output_permit_indicator(), .i_digital_terminals(term_in),
    .o_digital_terminals(term_out), .o_digital_terminals_oe_n(oe_n));
  save_engine_model save_engine_model_inst (.i_clk(clk), .i_save_req(save_req),
    .i_step_req(load | restore), .i_slow(slow), .o_save_done(save_done),
    .o_step_done(step_done));
  always #10 clk = ~clk;
  // Driven terminals read back their own level
  assign term_in = (~oe_n & term_out) | (oe_n & ext);
  // Hang guard and start-step monitor
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (load) saw_load <= 1'h1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // No bound here: only pready high or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Poll status until masked field matches, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'h0, power_fail_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while ((r & m) !== v && n < 200);
    chk(r & m, v);
  endtask
  task automatic wait_save(input logic v);
    int n;
    n = 0;
    while (save_req !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, save_req}, {31'h0, v});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    poll(32'h0000_0070, 32'h0000_0040);
    chk({31'h0, run}, 32'h0);
    $display("test boot done");
    dir = 8'($random(seed));
    cmd = 8'($random(seed));
    ext <= 8'($random(seed));
    apb(1'h1, power_fail_pkg::ADDR_CONTROL, 32'h7);
    apb(1'h1, power_fail_pkg::ADDR_DIRECTION, {24'h0, dir});
    apb(1'h1, power_fail_pkg::ADDR_OUT_CMD, {24'h0, cmd});
    apb(1'h1, 12'h020, 32'hFFFF_FFFF);
    apb(1'h0, 12'h020, 32'h0);
    chk(r, 32'h0);
    apb(1'h0, power_fail_pkg::ADDR_DIRECTION, 32'h0);
    chk(r, {24'h0, dir});
    repeat (6) @(posedge clk);
    apb(1'h0, power_fail_pkg::ADDR_TERM_READ, 32'h0);
    chk(r, {24'h0, (dir & cmd) | (~dir & ext)});
    chk({24'h0, oe_n}, {24'h0, ~dir});
    $display("test terminals done");
    // Dropout shorter than the qualifying time is ignored
    sup_low <= 1'h1;
    repeat (DROP / 2) @(posedge clk);
    sup_low <= 1'h0;
    repeat (40) @(posedge clk);
    poll(32'h3, 32'h0);
    // Long event: save, wait, recover
    sup_low <= 1'h1;
    sup_ok <= 1'h0;
    wait_save(1'h1);
    chk({22'h0, run, permit, oe_n}, {22'h0, 2'h0, 8'hFF});
    poll(32'h3, 32'h2);
    repeat (50) @(posedge clk);
    poll(32'h0000_0203, 32'h0000_0202);
    chk({24'h0, oe_n}, 32'h0000_00FF);
    sup_low <= 1'h0;
    sup_ok <= 1'h1;
    poll(32'h3, 32'h0);
    poll(32'h70, 32'h40);
    chk({30'h0, run, saw_load}, 32'h3);
    $display("test long event done");
    // Short event: recovery during a slow save
    slow <= 1'h1;
    sup_low <= 1'h1;
    sup_ok <= 1'h0;
    wait_save(1'h1);
    sup_low <= 1'h0;
    sup_ok <= 1'h1;
    repeat (20) @(posedge clk);
    chk({23'h0, save_req, oe_n}, {23'h0, 1'h1, 8'hFF});
    wait_save(1'h0);
    apb(1'h0, power_fail_pkg::ADDR_STATUS, 32'h0);
    chk(r & 32'h0000_0403, 32'h0000_0400);
    poll(32'h70, 32'h40);
    $display("test short event done");
    // Reserve runs out while waiting
    slow <= 1'h0;
    sup_low <= 1'h1;
    sup_ok <= 1'h0;
    poll(32'h3, 32'h2);
    repeat (10) @(posedge clk);
    exhaust <= 1'h1;
    poll(32'h3, 32'h3);
    chk({31'h0, active}, 32'h0);
    $display("test dead done");
    test_done();
  end
endmodule

// ===== tb/save_engine_model.sv
// Far-side model: flash save engine and start-step helper
`timescale 1ns/1ps
module save_engine_model (
  // Clock
  input  wire logic i_clk,
  // Requests from the controller
  input  wire logic i_save_req,
  input  wire logic i_step_req,
  input  wire logic i_slow,
  // Answers, one-cycle pulses
  output logic      o_save_done,
  output logic      o_step_done
);
  int save_cnt = 0; // Cycles into the current save
  int step_cnt = 0; // Cycles into the current step
  int lat;          // Slow save leaves room for recovery mid-save
  assign lat = i_slow ? 60 : 6;
  // Done only while asked; save done once per request, step done once every six cycles while asked
  always @(posedge i_clk) begin
    save_cnt <= i_save_req ? save_cnt + 1 : 0;
    o_save_done <= i_save_req && save_cnt == lat;
    step_cnt <= (i_step_req && !o_step_done) ? step_cnt + 1 : 0;
    o_step_done <= i_step_req && step_cnt == 4 && !o_step_done;
  end
endmodule
